// *** shared/mals_params.svh ***
`ifndef MALS_PARAMS_SVH
`define MALS_PARAMS_SVH

// Datapath widths
`define MALS_A_W 30
`define MALS_B_W 18
`define MALS_C_W 48
`define MALS_MUL_A_W 25
`define MALS_PROD_W 43
`define MALS_PP_LO_W 17
`define MALS_WIRE_SHIFT 17
`define MALS_LANE_W 12
`define MALS_LANES 4
`define MALS_OPSEL_W 7
`define MALS_ALU_W 4
`define MALS_CSEL_W 3

// Register byte offsets
`define MALS_OFF_CFG 8'h00
`define MALS_OFF_PAT_LO 8'h04
`define MALS_OFF_PAT_HI 8'h08
`define MALS_OFF_MSK_LO 8'h0C
`define MALS_OFF_MSK_HI 8'h10
`define MALS_OFF_RES_LO 8'h14
`define MALS_OFF_RES_HI 8'h18
`define MALS_OFF_FLAGS 8'h1C

// Configuration fields and reset values
`define MALS_CFG_MULTIPLIER_USE_SETTING 0
`define MALS_CFG_AREG 2:1
`define MALS_CFG_BREG 4:3
`define MALS_CFG_CREG 5
`define MALS_CFG_MREG 6
`define MALS_CFG_PREG 7
`define MALS_CFG_CTRLREG 8
`define MALS_CFG_ALUREG 9
`define MALS_CFG_CINREG 10
`define MALS_CFG_ACASC 11
`define MALS_CFG_BCASC 12
`define MALS_CFG_AR_PAT 13
`define MALS_CFG_AR_PATB 14
`define MALS_CFG_SIMD 16:15
`define MALS_CFG_RST 17'h00001
`define MALS_PAT_RST 48'h000000000000
`define MALS_MSK_RST 48'h000000000000

// Operand multiplexer selections
`define MALS_X_ZERO 2'h0
`define MALS_X_MUL 2'h1
`define MALS_X_P 2'h2
`define MALS_X_AB 2'h3
`define MALS_Y_ZERO 2'h0
`define MALS_Y_MUL 2'h1
`define MALS_Y_ONES 2'h2
`define MALS_Y_C 2'h3
`define MALS_Z_ZERO 3'h0
`define MALS_Z_RESULT_CHAIN_IN 3'h1
`define MALS_Z_P 3'h2
`define MALS_Z_C 3'h3
`define MALS_Z_SIGN 3'h4
`define MALS_Z_RESULT_CHAIN_IN_SH 3'h5
`define MALS_Z_P_SH 3'h6

// Alu function codes
`define MALS_ALU_ADD 4'h0
`define MALS_ALU_NEGADD 4'h1
`define MALS_ALU_NOTSUM 4'h2
`define MALS_ALU_SUB 4'h3
`define MALS_ALU_AND 4'h8
`define MALS_ALU_OR 4'h9
`define MALS_ALU_NOT 4'hA
`define MALS_ALU_NAND 4'hB
`define MALS_ALU_NOR 4'hC
`define MALS_ALU_XOR 4'hD
`define MALS_ALU_XNOR 4'hE

// Carry source selections
`define MALS_CIN_FABRIC 3'h0
`define MALS_CIN_RESULT_CHAIN_IN_RND 3'h1
`define MALS_CIN_CHAIN 3'h2
`define MALS_CIN_P_RND 3'h3
`define MALS_CIN_MUL_RND 3'h4
`define MALS_CIN_P_SIGN 3'h5
`define MALS_CIN_OWN 3'h6

// Bus responses
`define MALS_RESP_OKAY 2'h0
`define MALS_RESP_SLVERR 2'h2

`endif

// *** shared/mals_pkg.sv ***
package mals_pkg;

  typedef enum logic [1:0] {
    mals_one48,
    mals_two24,
    mals_four12
  } mals_simd_e;

  typedef struct packed {
    logic [6:0] opsel;
    logic [3:0] alufn;
    logic [2:0] csel;
  } mals_ctrl_s;

  typedef struct packed {
    logic a1;
    logic a2;
    logic b1;
    logic b2;
    logic c;
    logic m;
    logic p;
    logic ctrl;
    logic alu;
    logic cin;
  } mals_ce_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic m;
    logic p;
    logic ctrl;
    logic alu;
    logic cin;
  } mals_srst_s;

endpackage : mals_pkg

// *** rtl/mals_pipe_reg.sv ***
// Optional register with its own clock enable and synchronous clear
module mals_pipe_reg #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_use,
  input wire logic i_ce,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] q_q;

  // Synchronous clear outranks the enable
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_q <= '0;
    else if (i_srst)
      q_q <= '0;
    else if (i_ce)
      q_q <= i_d;
  end

  // Bypassed stage passes the input straight through
  assign o_q = i_use ? q_q : i_d;

endmodule : mals_pipe_reg

// *** rtl/mals_in_chain.sv ***
// Operand register chain, zero to two stages deep
module mals_in_chain #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_depth,
  input wire logic i_ce1,
  input wire logic i_ce2,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] stage1;

  // First stage only when two deep
  mals_pipe_reg #(.W(W)) u_first (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(i_depth == 2'h2),
    .i_ce(i_ce1),
    .i_srst(i_srst),
    .i_d(i_d),
    .o_q(stage1)
  );

  // Second stage for any non-zero depth, three included
  mals_pipe_reg #(.W(W)) u_second (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(i_depth != 2'h0),
    .i_ce(i_ce2),
    .i_srst(i_srst),
    .i_d(stage1),
    .o_q(o_q)
  );

endmodule : mals_in_chain

// *** rtl/mals_slice.sv ***
`include "mals_params.svh"

module mals_slice (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`MALS_A_W-1:0] i_a,
  input wire logic [`MALS_B_W-1:0] i_b,
  input wire logic [`MALS_C_W-1:0] i_c,
  input wire logic [`MALS_A_W-1:0] i_a_operand_chain_in,
  input wire logic [`MALS_B_W-1:0] i_b_operand_chain_in,
  input wire logic [`MALS_C_W-1:0] i_result_chain_in,
  input wire logic i_carry_chain_in,
  input wire logic i_product_sign_chain_in,
  input wire logic i_carry_in,
  input wire mals_pkg::mals_ctrl_s i_ctrl,
  input wire mals_pkg::mals_ce_s i_ce,
  input wire mals_pkg::mals_srst_s i_srst,
  output logic [`MALS_C_W-1:0] o_result,
  output logic [`MALS_C_W-1:0] o_result_chain_out,
  output logic [`MALS_A_W-1:0] o_a_operand_chain_out,
  output logic [`MALS_B_W-1:0] o_b_operand_chain_out,
  output logic [`MALS_LANES-1:0] o_lane_carry_out,
  output logic o_carry_chain_out,
  output logic o_product_sign_chain_out,
  output logic o_pattern_detect,
  output logic o_pattern_bar_detect,
  output logic o_overflow,
  output logic o_underflow,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  localparam int CW = `MALS_C_W;
  localparam int LW = `MALS_LANE_W;

  logic [16:0] cfg_q;
  logic [CW-1:0] pat_q;
  logic [CW-1:0] msk_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic [31:0] flags;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = data[i*8 +: 8];
    return r;
  endfunction : merge

  // Address and data are caught independently, in either order
  assign o_s_axi_awready = !aw_full_q;
  assign o_s_axi_wready = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  // Write address holder
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (i_s_axi_awvalid && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= i_s_axi_awaddr;
    end
    else if (wr_fire)
      aw_full_q <= 1'b0;
  end

  // Write data holder
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else if (i_s_axi_wvalid && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= i_s_axi_wdata;
      w_strb_q <= i_s_axi_wstrb;
    end
    else if (wr_fire)
      w_full_q <= 1'b0;
  end

  // Write response; results and flags are read-only and answer an error
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `MALS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == `MALS_OFF_CFG || aw_addr_q == `MALS_OFF_PAT_LO ||
          aw_addr_q == `MALS_OFF_PAT_HI ||
          aw_addr_q == `MALS_OFF_MSK_LO || aw_addr_q == `MALS_OFF_MSK_HI)
        bresp_q <= `MALS_RESP_OKAY;
      else
        bresp_q <= `MALS_RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      bvalid_q <= 1'b0;
  end
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  // Static slice settings
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_q <= `MALS_CFG_RST;
    else if (wr_fire && aw_addr_q == `MALS_OFF_CFG)
      cfg_q <= 17'(merge({15'h0000, cfg_q}, w_data_q, w_strb_q));
  end

  // Pattern, split over two words
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pat_q <= `MALS_PAT_RST;
    else if (wr_fire && aw_addr_q == `MALS_OFF_PAT_LO)
      pat_q[31:0] <= merge(pat_q[31:0], w_data_q, w_strb_q);
    else if (wr_fire && aw_addr_q == `MALS_OFF_PAT_HI)
      pat_q[47:32] <= 16'(merge({16'h0000, pat_q[47:32]}, w_data_q,
                            w_strb_q));
  end

  // Mask, split over two words
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      msk_q <= `MALS_MSK_RST;
    else if (wr_fire && aw_addr_q == `MALS_OFF_MSK_LO)
      msk_q[31:0] <= merge(msk_q[31:0], w_data_q, w_strb_q);
    else if (wr_fire && aw_addr_q == `MALS_OFF_MSK_HI)
      msk_q[47:32] <= 16'(merge({16'h0000, msk_q[47:32]}, w_data_q,
                            w_strb_q));
  end

  // Read port: one read in flight, answered one cycle after it is taken
  assign o_s_axi_arready = !rvalid_q;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `MALS_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else if (i_s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `MALS_RESP_OKAY;
      if (i_s_axi_araddr == `MALS_OFF_CFG)
        rdata_q <= {15'h0000, cfg_q};
      else if (i_s_axi_araddr == `MALS_OFF_PAT_LO)
        rdata_q <= pat_q[31:0];
      else if (i_s_axi_araddr == `MALS_OFF_PAT_HI)
        rdata_q <= {16'h0000, pat_q[47:32]};
      else if (i_s_axi_araddr == `MALS_OFF_MSK_LO)
        rdata_q <= msk_q[31:0];
      else if (i_s_axi_araddr == `MALS_OFF_MSK_HI)
        rdata_q <= {16'h0000, msk_q[47:32]};
      else if (i_s_axi_araddr == `MALS_OFF_RES_LO)
        rdata_q <= o_result[31:0];
      else if (i_s_axi_araddr == `MALS_OFF_RES_HI)
        rdata_q <= {16'h0000, o_result[47:32]};
      else if (i_s_axi_araddr == `MALS_OFF_FLAGS)
        rdata_q <= flags;
      else
      begin
        rdata_q <= 32'h00000000;
        rresp_q <= `MALS_RESP_SLVERR;
      end
    end
    else if (i_s_axi_rready)
      rvalid_q <= 1'b0;
  end
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rdata = rdata_q;

  // Datapath
  logic multiplier_use_setting;
  logic [`MALS_A_W-1:0] a_s;
  logic [`MALS_B_W-1:0] b_s;
  logic [CW-1:0] c_s;
  logic [9:0] ctrl_s;
  logic [3:0] alufn;
  logic [6:0] opsel;
  logic [2:0] csel;
  logic fab_cin;
  logic signed [`MALS_PROD_W-1:0] prod;
  logic [CW-1:0] pp_lo;
  logic [CW-1:0] pp_hi;
  logic [CW-1:0] m_lo;
  logic [CW-1:0] m_hi;
  logic m_sign;
  logic m_rnd;
  logic [CW-1:0] x;
  logic [CW-1:0] y;
  logic [CW-1:0] z;
  logic [CW-1:0] zz;
  logic cin;
  logic inv_z;
  logic inv_out;
  mals_pkg::mals_simd_e simd;
  logic [CW-1:0] sum;
  logic [CW-1:0] alu_out;
  logic [`MALS_LANES-1:0] lane_co;
  logic [`MALS_LANES-1:0] lane_end;
  logic [1:0] seg_cy [`MALS_LANES];
  logic [CW-1:0] p_q;
  logic pd;
  logic pdb;
  logic pd_q;
  logic pdb_q;
  logic pd_prev_q;
  logic pdb_prev_q;
  logic auto_clr;
  logic [`MALS_LANES-1:0] co_q;
  logic sign_q;

  assign multiplier_use_setting = cfg_q[`MALS_CFG_MULTIPLIER_USE_SETTING];

  // Operand chains, direct or from the neighbour
  mals_in_chain #(.W(`MALS_A_W)) u_a_chain (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_depth(cfg_q[`MALS_CFG_AREG]),
    .i_ce1(i_ce.a1),
    .i_ce2(i_ce.a2),
    .i_srst(i_srst.a),
    .i_d(cfg_q[`MALS_CFG_ACASC] ? i_a_operand_chain_in : i_a),
    .o_q(a_s)
  );
  mals_in_chain #(.W(`MALS_B_W)) u_b_chain (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_depth(cfg_q[`MALS_CFG_BREG]),
    .i_ce1(i_ce.b1),
    .i_ce2(i_ce.b2),
    .i_srst(i_srst.b),
    .i_d(cfg_q[`MALS_CFG_BCASC] ? i_b_operand_chain_in : i_b),
    .o_q(b_s)
  );
  assign o_a_operand_chain_out = a_s;
  assign o_b_operand_chain_out = b_s;

  // C keeps its own clear and enable
  mals_pipe_reg #(.W(CW)) u_c_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(cfg_q[`MALS_CFG_CREG]),
    .i_ce(i_ce.c),
    .i_srst(i_srst.c),
    .i_d(i_c),
    .o_q(c_s)
  );

  // Control codes, each group optionally registered
  mals_pipe_reg #(.W(10)) u_ctrl_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(cfg_q[`MALS_CFG_CTRLREG]),
    .i_ce(i_ce.ctrl),
    .i_srst(i_srst.ctrl),
    .i_d({i_ctrl.opsel, i_ctrl.csel}),
    .o_q(ctrl_s)
  );
  mals_pipe_reg #(.W(`MALS_ALU_W)) u_alu_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(cfg_q[`MALS_CFG_ALUREG]),
    .i_ce(i_ce.alu),
    .i_srst(i_srst.alu),
    .i_d(i_ctrl.alufn),
    .o_q(alufn)
  );
  mals_pipe_reg #(.W(1)) u_cin_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(cfg_q[`MALS_CFG_CINREG]),
    .i_ce(i_ce.cin),
    .i_srst(i_srst.cin),
    .i_d(i_carry_in),
    .o_q(fab_cin)
  );
  assign opsel = ctrl_s[9:3];
  assign csel = ctrl_s[2:0];

  // Product held at zero when the multiplier is switched off, saving toggles
  always_comb
  begin
    if (multiplier_use_setting)
      prod = $signed(a_s[`MALS_MUL_A_W-1:0]) * $signed(b_s);
    else
      prod = '0;
  end

  // Two partial products whose sum is the sign-extended product
  assign pp_lo = {31'h00000000, prod[`MALS_PP_LO_W-1:0]};
  assign pp_hi = {{5{prod[42]}}, prod[42:`MALS_PP_LO_W], 17'h00000};

  mals_pipe_reg #(.W(2*CW+2)) u_m_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_use(cfg_q[`MALS_CFG_MREG]),
    .i_ce(i_ce.m),
    .i_srst(i_srst.m),
    .i_d({pp_hi, pp_lo, prod[42], ~(a_s[24] ^ b_s[17])}),
    .o_q({m_hi, m_lo, m_sign, m_rnd})
  );

  // Operand multiplexers steered by the selector code
  always_comb
  begin
    case (opsel[1:0])
      `MALS_X_MUL: x = m_lo;
      `MALS_X_P: x = p_q;
      `MALS_X_AB: x = {a_s, b_s};
      default: x = '0;
    endcase
    case (opsel[3:2])
      `MALS_Y_MUL: y = m_hi;
      `MALS_Y_ONES: y = '1;
      `MALS_Y_C: y = c_s;
      default: y = '0;
    endcase
    case (opsel[6:4])
      `MALS_Z_RESULT_CHAIN_IN: z = i_result_chain_in;
      `MALS_Z_P: z = p_q;
      `MALS_Z_C: z = c_s;
      `MALS_Z_SIGN: z = {CW{i_product_sign_chain_in}};
      `MALS_Z_RESULT_CHAIN_IN_SH: z = CW'($signed(i_result_chain_in)
                                >>> `MALS_WIRE_SHIFT);
      `MALS_Z_P_SH: z = CW'($signed(p_q) >>> `MALS_WIRE_SHIFT);
      default: z = '0;
    endcase
  end

  // Carry source
  always_comb
  begin
    case (csel)
      `MALS_CIN_FABRIC: cin = fab_cin;
      `MALS_CIN_RESULT_CHAIN_IN_RND: cin = ~i_result_chain_in[47];
      `MALS_CIN_CHAIN: cin = i_carry_chain_in;
      `MALS_CIN_P_RND: cin = ~p_q[47];
      `MALS_CIN_MUL_RND: cin = m_rnd;
      `MALS_CIN_P_SIGN: cin = p_q[47];
      `MALS_CIN_OWN: cin = o_carry_chain_out;
      default: cin = 1'b0;
    endcase
  end

  // Lanes only split with the multiplier off: a product spans all 48 bits
  always_comb
  begin
    if (multiplier_use_setting || cfg_q[`MALS_CFG_SIMD] == 2'h3)
      simd = mals_pkg::mals_one48;
    else
      simd = mals_pkg::mals_simd_e'(cfg_q[`MALS_CFG_SIMD]);
  end

  // Subtraction done by inversion so each lane needs one adder only
  assign inv_z = alufn == `MALS_ALU_SUB || alufn == `MALS_ALU_NEGADD;
  assign inv_out = alufn == `MALS_ALU_SUB || alufn == `MALS_ALU_NOTSUM;
  assign zz = inv_z ? ~z : z;

  // Three-operand adder in 12-bit segments joined per lane mode
  for (genvar g = 0; g < `MALS_LANES; g++)
  begin : g_seg
    logic [13:0] seg_sum;
    logic [1:0] cy_in;
    if (g == 0)
    begin : g_first
      assign cy_in = {1'b0, cin};
    end
    else
    begin : g_next
      assign cy_in = (simd == mals_pkg::mals_four12 ||
                      (simd == mals_pkg::mals_two24 && g == 2)) ?
                     {1'b0, cin} : seg_cy[g-1];
    end
    assign seg_sum = 14'(x[g*LW +: LW]) + 14'(y[g*LW +: LW]) +
                     14'(zz[g*LW +: LW]) + 14'(cy_in);
    assign seg_cy[g] = seg_sum[13:12];
    assign lane_co[g] = |seg_sum[13:12];
    assign sum[g*LW +: LW] = seg_sum[LW-1:0];
  end

  // Only segments that end a lane report a carry
  always_comb
  begin
    case (simd)
      mals_pkg::mals_four12: lane_end = 4'hF;
      mals_pkg::mals_two24: lane_end = 4'hA;
      default: lane_end = 4'h8;
    endcase
  end

  // Arithmetic or bitwise logic, chosen each cycle
  always_comb
  begin
    case (alufn)
      `MALS_ALU_AND: alu_out = x & z;
      `MALS_ALU_OR: alu_out = x | z;
      `MALS_ALU_NOT: alu_out = ~z;
      `MALS_ALU_NAND: alu_out = ~(x & z);
      `MALS_ALU_NOR: alu_out = ~(x | z);
      `MALS_ALU_XOR: alu_out = x ^ z;
      `MALS_ALU_XNOR: alu_out = ~(x ^ z);
      default: alu_out = inv_out ? ~sum : sum;
    endcase
  end

  // Masked compare against the pattern and its complement
  assign pd = &(~(alu_out ^ pat_q) | msk_q);
  assign pdb = &(~(alu_out ^ ~pat_q) | msk_q);
  assign auto_clr = (cfg_q[`MALS_CFG_AR_PAT] && pd_q) ||
                    (cfg_q[`MALS_CFG_AR_PATB] && pdb_q);

  // Output register; a terminal count clears it the next time it loads
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      p_q <= '0;
    else if (i_srst.p)
      p_q <= '0;
    else if (i_ce.p)
      p_q <= auto_clr ? '0 : alu_out;
  end

  // Detector and carry history moves with the output register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pd_q <= 1'b0;
      pdb_q <= 1'b0;
      pd_prev_q <= 1'b0;
      pdb_prev_q <= 1'b0;
      co_q <= 4'h0;
      sign_q <= 1'b0;
    end
    else if (i_srst.p)
    begin
      pd_q <= 1'b0;
      pdb_q <= 1'b0;
      pd_prev_q <= 1'b0;
      pdb_prev_q <= 1'b0;
      co_q <= 4'h0;
      sign_q <= 1'b0;
    end
    else if (i_ce.p)
    begin
      pd_q <= pd;
      pdb_q <= pdb;
      pd_prev_q <= pd_q;
      pdb_prev_q <= pdb_q;
      co_q <= lane_co & lane_end;
      sign_q <= m_sign;
    end
  end

  // Output register may be bypassed; detectors always stay registered
  assign o_result = cfg_q[`MALS_CFG_PREG] ? p_q : alu_out;
  assign o_result_chain_out = o_result;
  assign o_lane_carry_out = co_q;
  assign o_carry_chain_out = co_q[3];
  assign o_product_sign_chain_out = sign_q;
  assign o_pattern_detect = pd_q;
  assign o_pattern_bar_detect = pdb_q;
  assign o_overflow = pd_prev_q && !pd_q && !pdb_q;
  assign o_underflow = pdb_prev_q && !pd_q && !pdb_q;
  assign flags = {22'h000000, co_q, sign_q, o_carry_chain_out,
                  o_underflow, o_overflow, pdb_q, pd_q};

endmodule : mals_slice

// *** test/mals_nbr_model.sv ***
// Neighbouring slice above this one in the column
module mals_nbr_model (
  input wire logic i_clk,
  input wire logic [47:0] i_val,
  output logic [47:0] o_pc,
  output logic o_carry,
  output logic o_sign,
  output logic [29:0] o_ac,
  output logic [17:0] o_bc
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cascade outputs leave a register, as a real neighbour's carry and sign do; its result and operand chains only with PREG, AREG and BREG on
  always_ff @(posedge i_clk)
  begin
    o_pc <= i_val;
    o_carry <= i_val[17];
    o_sign <= i_val[47];
    {o_ac, o_bc} <= i_val;
  end
endmodule : mals_nbr_model

// *** test/mals_slice_checker.sv ***
// Port-level watch on the result group of the slice
module mals_slice_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire mals_pkg::mals_ce_s i_ce,
  input wire mals_pkg::mals_srst_s i_srst,
  input wire logic [47:0] o_result,
  input wire logic [47:0] o_result_chain_out,
  input wire logic [3:0] o_lane_carry_out,
  input wire logic o_carry_chain_out,
  input wire logic o_product_sign_chain_out,
  input wire logic o_pattern_detect,
  input wire logic o_pattern_bar_detect,
  input wire logic o_overflow,
  input wire logic o_underflow
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Output-stage flags may only move when that stage loads or clears
  wire logic idle = !i_ce.p && !i_srst.p;
  wire logic [1:0] det = {o_pattern_detect, o_pattern_bar_detect};
  property p_chain; o_result_chain_out == o_result; endproperty
  a_chain: assert property (p_chain) else $error("chain out");
  property p_cchain; o_carry_chain_out == o_lane_carry_out[3]; endproperty
  a_cchain: assert property (p_cchain) else $error("carry out");
  property p_dhold; idle |=> $stable(det); endproperty
  a_dhold: assert property (p_dhold) else $error("det moved");
  property p_lhold; idle |=> $stable(o_lane_carry_out); endproperty
  a_lhold: assert property (p_lhold) else $error("lane moved");
  property p_shold; idle |=> $stable(o_product_sign_chain_out); endproperty
  a_shold: assert property (p_shold) else $error("sign moved");
  property p_clr; i_srst.p |=> o_lane_carry_out == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_ovf; o_overflow |-> det == 2'h0; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow");
  property p_unf; o_underflow |-> det == 2'h0; endproperty
  a_unf: assert property (p_unf) else $error("underflow");
  c_lane: cover property (o_lane_carry_out[1]);
  c_ovf: cover property (o_overflow);
  c_unf: cover property (o_underflow);
endmodule : mals_slice_checker

bind mals_slice mals_slice_checker i_mals_slice_checker (.*);

// *** test/multiply_add_logic_slice_test.sv ***
`include "mals_params.svh"

module multiply_add_logic_slice_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [29:0] a = 30'h0;
  logic [17:0] b = 18'h0;
  logic [47:0] c = 48'h0;
  logic cin = 1'h0;
  logic [47:0] nv = 48'h800000020000;
  mals_pkg::mals_ctrl_s ctrl = 14'h0;
  mals_pkg::mals_ce_s ce = 10'h3FF;
  mals_pkg::mals_srst_s sr = 8'h0;
  logic [7:0] aw = 8'h0, ar = 8'h0;
  logic [31:0] wd = 32'h0, rdat, rdv;
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
  logic awr, wrr, bv, arr, rv;
  logic [1:0] bresp, rresp, rs;
  logic [47:0] res, pc;
  logic [29:0] ac;
  logic [17:0] bc;
  logic [3:0] lco;
  logic cco, kc, sg, pd, pdb, ovf, unf;
  int fails = 0, tests_run = 0, cyc = 0;

  mals_slice i_mals_slice (.i_clk(clk), .i_rst_n(rst_n), .i_a(a), .i_b(b),
    .i_c(c), .i_a_operand_chain_in(ac), .i_b_operand_chain_in(bc),
    .i_result_chain_in(pc), .i_carry_chain_in(kc),
    .i_product_sign_chain_in(sg), .i_carry_in(cin), .i_ctrl(ctrl),
    .i_ce(ce), .i_srst(sr), .o_result(res), .o_result_chain_out(),
    .o_a_operand_chain_out(), .o_b_operand_chain_out(),
    .o_lane_carry_out(lco), .o_carry_chain_out(cco),
    .o_product_sign_chain_out(), .o_pattern_detect(pd),
    .o_pattern_bar_detect(pdb), .o_overflow(ovf), .o_underflow(unf),
    .i_s_axi_awaddr(aw), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(brdy), .i_s_axi_araddr(ar), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy));
  mals_nbr_model i_mals_nbr_model (.i_clk(clk), .i_val(nv), .o_pc(pc),
    .o_carry(kc), .o_sign(sg), .o_ac(ac), .o_bc(bc));

  // Clock, and a hang guard far beyond the hundred or so cycles needed
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks %0d bad %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic ck(input string n, input logic [47:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask : ck

  // Bus write; each channel is dropped only once its ready was seen
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    aw <= ad;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'h0;
      if (wrr)
        wv <= 1'h0;
    end
    while (!bv);
    rs = bresp;
    brdy <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    ar <= ad;
    arv <= 1'h1;
    rrdy <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'h0;
    end
    while (!rv);
    rdv = rdat;
    rs = rresp;
    rrdy <= 1'h0;
  endtask : rd

  // Drive codes and operands, then look once the adder has settled
  task automatic dp(input logic [6:0] o, input logic [3:0] f,
    input logic [2:0] s, input logic [47:0] x, z);
    @(posedge clk);
    ctrl <= {o, f, s};
    {a, b} <= x;
    c <= z;
    @(negedge clk);
  endtask : dp

  task automatic tk;
    @(posedge clk);
    @(negedge clk);
  endtask : tk

  task automatic t_reg;
    rd(`MALS_OFF_CFG);
    ck("cfg", 48'h1, rdv);
    rd(8'h22);
    ck("rresp", 48'h2, rs);
    wr(`MALS_OFF_FLAGS, 32'h1);
    ck("bresp", 48'h2, rs);
    $display("reg done");
  endtask : t_reg

  task automatic t_mul;
    dp(7'h05, 4'h0, 3'h0, {30'h2BFFFFF9, 18'h3}, 48'h0);
    ck("mul", 48'hFFFFFFFFFFEB, res);
    dp(7'h05, 4'h0, 3'h0, {30'h00FFFFFF, 18'h3FFFF}, 48'h0);
    ck("mul", 48'hFFFFFF000001, res);
    $display("mul done");
  endtask : t_mul

  task automatic t_add;
    wr(`MALS_OFF_CFG, 32'h0);
    dp(7'h3F, 4'h0, 3'h0, 48'h000100000002, 48'h10);
    ck("add", 48'h000100000022, res);
    dp(7'h3F, 4'h3, 3'h0, 48'h000100000002, 48'h10);
    ck("sub", 48'hFFFEFFFFFFFE, res);
    $display("add done");
  endtask : t_add

  task automatic t_logic;
    logic [47:0] ex [7] = '{48'hF000F000F000, 48'hFFF0FFF0FFF0,
      48'h0F0F0F0F0F0F, 48'h0FFF0FFF0FFF, 48'h000F000F000F,
      48'h0FF00FF00FF0, 48'hF00FF00FF00F};
    for (int i = 0; i < 7; i++)
    begin
      dp(7'h33, 4'(8 + i), 3'h0, 48'hFF00FF00FF00, 48'hF0F0F0F0F0F0);
      ck("logic", ex[i], res);
    end
    $display("logic done");
  endtask : t_logic

  // Four lanes, then the same with the multiplier on, which forbids lanes
  task automatic t_simd;
    wr(`MALS_OFF_CFG, 32'h10000);
    dp(7'h33, 4'h0, 3'h0, 48'hFFF001FFF000, 48'h001001001001);
    ck("lanes", 48'h000002000001, res);
    tk;
    ck("lcarry", 48'hA, lco);
    ck("cchain", 48'h1, cco);
    wr(`MALS_OFF_CFG, 32'h10001);
    dp(7'h33, 4'h0, 3'h0, 48'hFFF001FFF000, 48'h001001001001);
    ck("one48", 48'h000003000001, res);
    tk;
    ck("lcarry", 48'h8, lco);
    @(posedge clk);
    sr.p <= 1'h1;
    @(posedge clk);
    sr.p <= 1'h0;
    @(negedge clk);
    ck("clear", 48'h0, lco);
    $display("simd done");
  endtask : t_simd

  task automatic t_pat;
    logic [47:0] cv [5] = '{48'h456789ABCDEF, 48'hBA9876543210, 48'h0,
      48'h456789ABCDEF, 48'h0};
    logic [3:0] fl [5] = '{4'h8, 4'h4, 4'h1, 4'h8, 4'h2};
    wr(`MALS_OFF_CFG, 32'h0);
    wr(`MALS_OFF_PAT_LO, 32'h89ABCDEF);
    wr(`MALS_OFF_PAT_HI, 32'h4567);
    for (int i = 0; i < 5; i++)
    begin
      dp(7'h30, 4'h0, 3'h0, 48'h0, cv[i]);
      tk;
      ck("flags", fl[i], {pd, pdb, ovf, unf});
    end
    @(posedge clk);
    ce.p <= 1'h0;
    c <= cv[0];
    tk;
    ck("hold", 48'h0, {pd, pdb, ovf, unf});
    @(posedge clk);
    ce.p <= 1'h1;
    $display("pattern done");
  endtask : t_pat

  // Cascade inputs from the neighbour, fabric carry held high throughout
  task automatic t_chain;
    @(posedge clk);
    cin <= 1'h1;
    dp(7'h10, 4'h0, 3'h7, 48'h0, 48'h0);
    ck("result_chain_in", nv, res);
    dp(7'h50, 4'h0, 3'h7, 48'h0, 48'h0);
    ck("shift", 48'hFFFFC0000001, res);
    dp(7'h40, 4'h0, 3'h7, 48'h0, 48'h0);
    ck("sign", 48'hFFFFFFFFFFFF, res);
    dp(7'h10, 4'h0, 3'h2, 48'h0, 48'h0);
    ck("cchain", 48'h800000020001, res);
    dp(7'h10, 4'h0, 3'h0, 48'h0, 48'h0);
    ck("cfab", 48'h800000020001, res);
    rd(`MALS_OFF_RES_LO);
    ck("rlo", 48'h20001, rdv);
    $display("chain done");
  endtask : t_chain

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_reg;
    t_mul;
    t_add;
    t_logic;
    t_simd;
    t_pat;
    t_chain;
    stop_test;
  end
endmodule : multiply_add_logic_slice_test
